// >>> inc/rsfs_pkg.sv
// Constants, state codes and comparator carrier for the regulator startup sequencer
package rsfs_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_INIT_DELAY_NS = 1360000;
   localparam int INIT_DELAY_CYC = T_INIT_DELAY_NS / CLK_PERIOD_NS;
   localparam int T_BOOT_HOLD_NS = 85000;
   localparam int HOLD_CYC = (T_BOOT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_VID_QUAL_NS = 500;
   localparam int VID_QUAL_CYC = (T_VID_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_READY_DELAY_NS = 85000;
   localparam int READY_CYC = (T_READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HICCUP_SW_CYC = 4096;
   localparam int OC_RUN_CYC = 8;
   // Widths
   localparam int NUM_PHASES = 6;
   localparam int DAC_W = 9;
   localparam int VID_W = 8;
   localparam int IRQ_W = 5;
   // Reference levels in 6.25 mV DAC steps
   localparam logic [8:0] BOOT_LEVEL = 9'h0B0;
   localparam logic [8:0] VID_BASE = 9'h102;
   localparam logic [7:0] VID_FIRST = 8'h02;
   localparam logic [7:0] VID_LAST = 8'hB2;
   // Register byte offsets
   localparam logic [4:0] REG_OFFSET = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_IRQ_STATUS = 5'h08;
   localparam logic [4:0] REG_IRQ_CLEAR = 5'h0C;
   localparam logic [4:0] REG_IRQ_ENABLE = 5'h10;
   // Reset values
   localparam logic [7:0] OFFSET_RST = 8'h00;
   localparam logic [4:0] IRQ_EN_RST = 5'h00;
   // Interrupt bit positions
   localparam int IRQ_READY_UP = 0;
   localparam int IRQ_READY_DN = 1;
   localparam int IRQ_OV = 2;
   localparam int IRQ_OC = 3;
   localparam int IRQ_OFF = 4;

   // Sequencer states, Gray along the start path
   typedef enum logic [2:0] {
      ST_SHUT = 3'h0,
      ST_DELAY = 3'h1,
      ST_RAMP_BOOT = 3'h3,
      ST_HOLD = 3'h2,
      ST_RAMP_TGT = 3'h6,
      ST_RUN = 3'h7,
      ST_HICCUP = 3'h5,
      ST_OFF = 3'h4
   } rsfs_state_e;

   // Digital results of the analog comparators
   typedef struct packed {
      logic por_ok;
      logic power_rail_enable_in;
      logic termination_rail_enable_in;
      logic sense_below_half;
      logic sense_above_recover;
      logic ov_fixed_trip;
      logic ov_coded_trip;
      logic differential_sense_level;
      logic avg_overcurrent;
   } rsfs_cmp_s;
endpackage : rsfs_pkg

// >>> sim/regulator_startup_fault_sequencer_tb.sv
// Self-checking bench for the regulator startup and fault sequencer
`timescale 1ns/100ps
module regulator_startup_fault_sequencer_tb;
   import rsfs_pkg::*;
   logic clk;
   logic rst_b = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic sw = 1'b0;
   logic ss = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wd = 32'h0;
   rsfs_cmp_s cmp = '0;
   logic [5:0] coc = 6'h00;
   logic [7:0] code_req = 8'h20;
   logic [7:0] code;
   logic [31:0] rdata, q;
   logic [5:0] lvl, oe;
   logic [8:0] dac;
   logic wt, ovsel, rdy, irq, low_on, all_off;
   int failures = 0;
   int checks = 0;
   int n;
   ////////////////////////////////////////
   // Clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Short initial delay keeps the run brief
   rsfs_sequencer #(.P_INIT_DELAY_CYC(20)) dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(addr),
      .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wt), .I_CMP(cmp), .I_CHAN_OC(coc),
      .I_VOLTAGE_CODE_IN(code), .I_SW_CYCLE(sw), .I_SS_OSC(ss), .I_PWM_DEMAND(6'h2A),
      .O_PWM_LEVEL(lvl), .O_PWM_OE(oe), .O_REF_DAC(dac), .O_OV_SEL_CODED(ovsel),
      .O_REGULATOR_READY(rdy), .O_IRQ(irq));
   rsfs_far_model far (.i_clk(clk), .i_code_req(code_req), .i_pwm_level(lvl), .i_pwm_oe(oe),
      .o_voltage_code_in(code), .o_low_fets_on(low_on), .o_all_fets_off(all_off));
   ////////////////////////////////////////
   // Every task is entered and left just after a rising edge
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   // One Avalon word; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
         k++;
      end while (wt !== 1'b0 && k < 50);
      q = rdata;
      if (k >= 50) failures++;
      rd <= 1'b0;
      wr <= 1'b0;
      tick(1);
   endtask : bus
   task automatic st_is(input logic [2:0] st);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(q[2:0], st);
   endtask : st_is
   // Edges are four clocks apart, well below a third of the clock rate
   task automatic pulse(input logic is_ss);
      if (is_ss) ss <= 1'b1;
      else sw <= 1'b1;
      tick(2);
      ss <= 1'b0;
      sw <= 1'b0;
      tick(2);
   endtask : pulse
   // Step the soft-start oscillator until the wanted state shows, bounded
   task automatic go(input logic [2:0] st);
      int k;
      k = 0;
      do begin
         pulse(1'b1);
         bus(1'b0, REG_STATUS, 32'h0);
         k++;
      end while (q[2:0] !== st && k < 1000);
      chk(q[2:0], st);
   endtask : go
   task automatic do_reset();
      rst_b <= 1'b0;
      tick(2);
      rst_b <= 1'b1;
      tick(1);
   endtask : do_reset
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////
   // Whole run is about 35k clocks; the limit leaves ample room
   initial begin
      #(100000 * 40);
      failures++;
      report_and_stop();
   end
   // Scenarios
   initial begin
      tick(2);
      rst_b <= 1'b1;
      tick(1);
      chk({oe, rdy, irq, wt}, 9'h001);
      bus(1'b0, REG_OFFSET, 32'h0);
      chk(q, {24'h0, OFFSET_RST});
      bus(1'b0, REG_IRQ_ENABLE, 32'h0);
      chk(q, {27'h0, IRQ_EN_RST});
      bus(1'b0, 5'h14, 32'h0);
      chk(q, 32'h0);
      // Overvoltage guard with supply good but both enables low
      cmp.por_ok <= 1'b1;
      cmp.ov_fixed_trip <= 1'b1;
      cmp.differential_sense_level <= 1'b1;
      tick(4);
      chk({oe, low_on}, {6'h3F, 1'b1});
      cmp.ov_fixed_trip <= 1'b0;
      cmp.differential_sense_level <= 1'b0;
      tick(4);
      chk(all_off, 1'b1);
      do_reset();
      bus(1'b1, REG_OFFSET, 32'h2);
      bus(1'b1, REG_IRQ_ENABLE, 32'h1);
      // Start-up path
      cmp.power_rail_enable_in <= 1'b1;
      cmp.sense_above_recover <= 1'b1;
      tick(10);
      st_is(ST_SHUT);
      cmp.termination_rail_enable_in <= 1'b1;
      tick(4);
      st_is(ST_DELAY);
      tick(8);
      st_is(ST_DELAY);
      tick(20);
      st_is(ST_RAMP_BOOT);
      chk(q[24:16], 9'h000);
      pulse(1'b1);
      tick(4);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(q[24:16], 9'h001);
      go(ST_HOLD);
      chk({q[24:16], dac, ovsel}, {BOOT_LEVEL, BOOT_LEVEL, 1'b0});
      go(ST_RUN);
      chk({q[24:16], q[5], ovsel}, {VID_BASE - 9'h022, 2'b11});
      chk({rdy, oe, lvl}, {1'b0, 6'h3F, 6'h2A});
      tick(2100);
      chk(rdy, 1'b0);
      tick(40);
      chk({rdy, irq}, 2'b11);
      bus(1'b1, REG_IRQ_CLEAR, 32'h1);
      chk(irq, 1'b0);
      // Undervoltage with hysteresis
      cmp.sense_above_recover <= 1'b0;
      cmp.sense_below_half <= 1'b1;
      tick(5);
      chk(rdy, 1'b0);
      cmp.sense_below_half <= 1'b0;
      tick(10);
      chk(rdy, 1'b0);
      cmp.sense_above_recover <= 1'b1;
      n = 0;
      while (rdy !== 1'b1 && n < 3000) begin
         tick(1);
         n++;
      end
      chk(rdy, 1'b1);
      // One phase over current: seven cycles tolerated, the eighth trips
      coc <= 6'h08;
      tick(4);
      repeat (7) pulse(1'b0);
      tick(4);
      st_is(ST_RUN);
      pulse(1'b0);
      tick(4);
      st_is(ST_HICCUP);
      chk(oe, 6'h00);
      coc <= 6'h00;
      repeat (4095) pulse(1'b0);
      tick(4);
      st_is(ST_HICCUP);
      pulse(1'b0);
      tick(4);
      st_is(ST_DELAY);
      go(ST_RUN);
      cmp.avg_overcurrent <= 1'b1;
      tick(5);
      st_is(ST_HICCUP);
      cmp.avg_overcurrent <= 1'b0;
      do_reset();
      // Overvoltage while running latches the block off
      go(ST_RUN);
      cmp.ov_coded_trip <= 1'b1;
      cmp.differential_sense_level <= 1'b1;
      tick(4);
      chk(low_on, 1'b1);
      cmp.ov_coded_trip <= 1'b0;
      tick(4);
      chk({low_on, rdy}, 2'b10);
      cmp.differential_sense_level <= 1'b0;
      tick(4);
      chk(all_off, 1'b1);
      code_req <= 8'h30;
      tick(20);
      st_is(ST_SHUT);
      cmp.power_rail_enable_in <= 1'b0;
      tick(5);
      cmp.power_rail_enable_in <= 1'b1;
      tick(5);
      st_is(ST_DELAY);
      // Off code read at the end of the hold
      code_req <= 8'hFF;
      go(ST_OFF);
      code_req <= 8'h20;
      tick(50);
      st_is(ST_OFF);
      chk(rdy, 1'b0);
      cmp.termination_rail_enable_in <= 1'b0;
      tick(5);
      cmp.termination_rail_enable_in <= 1'b1;
      tick(5);
      st_is(ST_DELAY);
      report_and_stop();
   end
endmodule : regulator_startup_fault_sequencer_tb

// >>> sim/rsfs_far_model.sv
// Far-side model: processor code pins and the phase drivers' reading of the PWM pins
`timescale 1ns/100ps
module rsfs_far_model
   import rsfs_pkg::*;
(
   input wire logic i_clk, // System clock
   input wire logic [VID_W-1:0] i_code_req, // Code the processor wants to show
   input wire logic [NUM_PHASES-1:0] i_pwm_level, // PWM level from the block
   input wire logic [NUM_PHASES-1:0] i_pwm_oe, // PWM drive enable from the block
   output logic [VID_W-1:0] o_voltage_code_in, // Code pins
   output logic o_low_fets_on, // Every driver has its lower switch on
   output logic o_all_fets_off // Every driver sees high-Z and turns both switches off
);
   // The processor moves its pins one clock late, so the block must not rely on alignment
   always_ff @(posedge i_clk) begin
      o_voltage_code_in <= i_code_req;
   end
   ////////////////////////////////////////
   // Drivers: a driven low pin turns the lower switch on, a floating pin turns all off
   assign o_low_fets_on = &(i_pwm_oe & ~i_pwm_level);
   assign o_all_fets_off = ~|i_pwm_oe;
endmodule : rsfs_far_model

// >>> src/rsfs_sequencer.sv
// Startup, ready and fault sequencer for a multiphase core regulator
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - Shutdown leaves every PWM output high-impedance unless overvoltage pulls them low.
// - Leave shutdown only with supply good and both enables high.
// - Ramp to boot level, hold, then read the voltage code.
// - Off code shuts down until supply or an enable is cycled.
// - Wait a fixed initial delay before the first ramp.
// - Boot hold is a fixed time plus a minimum code qualification.
// - Ramps move the DAC one step per soft-start tick.
// - Valid code starts a second ramp to code minus offset.
// - Ready low in shutdown, high after soft-start plus fixed delay.
// - Ready drops on under or overvoltage, disable or off code.
// - Undervoltage at half, recovery at the higher fraction.
// - Overvoltage guard active from supply good, enabled or not.
// - Fixed overvoltage level until valid code, then code-based level.
// - Overvoltage drives PWM low until differential sense falls, then high-Z.
// - Overvoltage latches off until an enable or supply is cycled.
// - Averaged overcurrent trips shutdown at once.
// - Channel overcurrent for eight switching cycles trips shutdown.
// - Overcurrent: PWM high-Z, wait 4096 switching cycles, retry.
module rsfs_sequencer #(
   parameter int P_INIT_DELAY_CYC = rsfs_pkg::INIT_DELAY_CYC // Initial delay in clocks
) (
   input wire logic I_SYS_CLK, // 25 MHz clock
   input wire logic I_RST_B, // Sync reset, active low
   input wire logic [4:0] I_AVS_ADDRESS, // Byte address
   input wire logic I_AVS_READ, // Read request
   input wire logic I_AVS_WRITE, // Write request
   input wire logic [31:0] I_AVS_WRITEDATA, // Write data
   input wire logic [3:0] I_AVS_BYTEENABLE, // Byte enables
   output logic [31:0] O_AVS_READDATA, // Read data
   output logic O_AVS_WAITREQUEST, // Stall
   input wire rsfs_pkg::rsfs_cmp_s I_CMP, // Comparator pins
   input wire logic [rsfs_pkg::NUM_PHASES-1:0] I_CHAN_OC, // Per-phase overcurrent
   input wire logic [rsfs_pkg::VID_W-1:0] I_VOLTAGE_CODE_IN, // Processor code
   input wire logic I_SW_CYCLE, // Switching cycle marker
   input wire logic I_SS_OSC, // Soft-start oscillator
   input wire logic [rsfs_pkg::NUM_PHASES-1:0] I_PWM_DEMAND, // Modulator PWM
   output logic [rsfs_pkg::NUM_PHASES-1:0] O_PWM_LEVEL, // PWM drive level
   output logic [rsfs_pkg::NUM_PHASES-1:0] O_PWM_OE, // PWM drive enable
   output logic [rsfs_pkg::DAC_W-1:0] O_REF_DAC, // Reference DAC code
   output logic O_OV_SEL_CODED, // Overvoltage level select
   output logic O_REGULATOR_READY, // Ready output
   output logic O_IRQ // Interrupt, level
);
   import rsfs_pkg::*;

   rsfs_cmp_s cmp_s1_reg, cmp_s2_reg;
   logic [NUM_PHASES-1:0] coc_s1_reg, coc_s2_reg;
   logic [VID_W-1:0] vid_s1_reg, vid_s2_reg, vid_s3_reg;
   logic [2:0] sw_sh_reg, ss_sh_reg;
   rsfs_state_e state_reg, state_next;
   logic [15:0] tmr_reg, tmr_next;
   logic [DAC_W-1:0] dac_reg, dac_next, tgt_reg, tgt_next;
   logic [3:0] vstab_reg;
   logic ov_latch_reg, ov_pull_reg, ov_sel_reg, uv_ok_reg;
   logic [7:0] offset_reg;
   logic [IRQ_W-1:0] irq_st_reg, irq_en_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [NUM_PHASES-1:0] pwm_lvl_reg, pwm_oe_reg;
   logic ready_reg, irq_reg;
   logic [3:0] ccnt_reg [NUM_PHASES];

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers; vid_s3 only feeds the stability check
   always_ff @(posedge I_SYS_CLK) begin
      cmp_s1_reg <= I_CMP;
      cmp_s2_reg <= cmp_s1_reg;
      coc_s1_reg <= I_CHAN_OC;
      coc_s2_reg <= coc_s1_reg;
      vid_s1_reg <= I_VOLTAGE_CODE_IN;
      vid_s2_reg <= vid_s1_reg;
      vid_s3_reg <= vid_s2_reg;
      sw_sh_reg <= {sw_sh_reg[1:0], I_SW_CYCLE};
      ss_sh_reg <= {ss_sh_reg[1:0], I_SS_OSC};
   end

   // Decoded conditions
   wire en_ok = cmp_s2_reg.por_ok & cmp_s2_reg.power_rail_enable_in & cmp_s2_reg.termination_rail_enable_in;
   wire sw_tick = sw_sh_reg[1] & ~sw_sh_reg[2];
   wire ss_tick = ss_sh_reg[1] & ~ss_sh_reg[2];
   wire ov_level = ov_sel_reg ? cmp_s2_reg.ov_coded_trip : cmp_s2_reg.ov_fixed_trip;
   wire ov_now = cmp_s2_reg.por_ok & ov_level;
   wire vid_ok = (vstab_reg == 4'(VID_QUAL_CYC));
   wire vid_off = (vid_s2_reg < VID_FIRST) | (vid_s2_reg > VID_LAST);
   wire [9:0] tgt_raw = {1'b0, VID_BASE} - {2'h0, vid_s2_reg} - {2'h0, offset_reg};
   wire [DAC_W-1:0] tgt_calc = tgt_raw[9] ? 9'h000 : tgt_raw[8:0];
   wire active = (state_reg == ST_RAMP_BOOT) | (state_reg == ST_HOLD) | (state_reg == ST_RAMP_TGT) |
      (state_reg == ST_RUN);
   wire [NUM_PHASES-1:0] chan_trip;
   wire oc_trip = active & (cmp_s2_reg.avg_overcurrent | (|chan_trip));

   ////////////////////////////////////////////////////////////////////////
   // Per-phase run counters: a single quiet cycle restarts the count
   generate
      for (genvar i = 0; i < NUM_PHASES; i++) begin : g_chan
         always_ff @(posedge I_SYS_CLK) begin
            if (!I_RST_B || !active) begin
               ccnt_reg[i] <= 4'h0;
            end else if (sw_tick) begin
               ccnt_reg[i] <= !coc_s2_reg[i] ? 4'h0 : (chan_trip[i] ? ccnt_reg[i] : ccnt_reg[i] + 4'h1);
            end
         end
         assign chan_trip[i] = (ccnt_reg[i] == 4'(OC_RUN_CYC));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Code stability counter, saturates at the qualification time
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B || (vid_s2_reg != vid_s3_reg)) begin
         vstab_reg <= 4'h0;
      end else if (!vid_ok) begin
         vstab_reg <= vstab_reg + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state; disable and overvoltage latch win over all
   always_comb begin
      state_next = state_reg;
      tmr_next = tmr_reg;
      dac_next = dac_reg;
      tgt_next = tgt_reg;
      unique case (state_reg)
         ST_SHUT: begin
            dac_next = 9'h000;
            tmr_next = 16'h0000;
            if (en_ok && !ov_latch_reg) begin
               state_next = ST_DELAY;
            end
         end
         ST_DELAY: begin
            tmr_next = tmr_reg + 16'h0001;
            if (tmr_reg == 16'(P_INIT_DELAY_CYC - 1)) begin
               state_next = ST_RAMP_BOOT;
               tmr_next = 16'h0000;
            end
         end
         ST_RAMP_BOOT: begin
            if (dac_reg == BOOT_LEVEL) begin
               state_next = ST_HOLD;
            end else if (ss_tick) begin
               dac_next = dac_reg + 9'h001;
            end
         end
         ST_HOLD: begin
            if (tmr_reg != 16'(HOLD_CYC - 1)) begin
               tmr_next = tmr_reg + 16'h0001;
            end else if (vid_ok) begin
               tgt_next = tgt_calc;
               state_next = vid_off ? ST_OFF : ST_RAMP_TGT;
            end
         end
         ST_RAMP_TGT: begin
            tmr_next = 16'h0000;
            if (dac_reg == tgt_reg) begin
               state_next = ST_RUN;
            end else if (ss_tick) begin
               dac_next = (dac_reg < tgt_reg) ? dac_reg + 9'h001 : dac_reg - 9'h001;
            end
         end
         ST_RUN: begin
            if (tmr_reg != 16'(READY_CYC)) begin
               tmr_next = tmr_reg + 16'h0001;
            end
            if (vid_ok && vid_off) begin
               state_next = ST_OFF;
            end
         end
         ST_HICCUP: begin
            dac_next = 9'h000;
            if (sw_tick) begin
               tmr_next = tmr_reg + 16'h0001;
               if (tmr_reg == 16'(HICCUP_SW_CYC - 1)) begin
                  state_next = ST_DELAY;
                  tmr_next = 16'h0000;
               end
            end
         end
         ST_OFF: begin
            dac_next = 9'h000;
         end
      endcase
      if (oc_trip) begin
         state_next = ST_HICCUP;
         tmr_next = 16'h0000;
         dac_next = 9'h000;
      end
      if (!en_ok || ov_latch_reg) begin
         state_next = ST_SHUT;
         dac_next = 9'h000;
      end
   end

   // Fault flags and PWM drive
   wire drive = active & ~ov_latch_reg;
   wire ov_pull_next = ov_now | (ov_pull_reg & cmp_s2_reg.differential_sense_level);
   wire ov_latch_next = ov_now | (ov_latch_reg & en_ok);
   wire ov_sel_next = (state_next == ST_RAMP_TGT) | (state_next == ST_RUN);
   wire uv_ok_next = cmp_s2_reg.sense_below_half ? 1'b0 : (cmp_s2_reg.sense_above_recover ? 1'b1 : uv_ok_reg);
   wire [NUM_PHASES-1:0] oe_next = (ov_pull_next | drive) ? {NUM_PHASES{1'b1}} : {NUM_PHASES{1'b0}};
   wire [NUM_PHASES-1:0] lvl_next = (drive & ~ov_pull_next) ? I_PWM_DEMAND : {NUM_PHASES{1'b0}};
   wire ready_next = (state_reg == ST_RUN) & (tmr_reg == 16'(READY_CYC)) & uv_ok_reg & ~ov_now & en_ok;

   ////////////////////////////////////////////////////////////////////////
   // State, fault and output registers
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         state_reg <= ST_SHUT;
         tmr_reg <= 16'h0000;
         dac_reg <= 9'h000;
         tgt_reg <= 9'h000;
         ov_latch_reg <= 1'b0;
         ov_pull_reg <= 1'b0;
         ov_sel_reg <= 1'b0;
         uv_ok_reg <= 1'b0;
         pwm_oe_reg <= {NUM_PHASES{1'b0}};
         pwm_lvl_reg <= {NUM_PHASES{1'b0}};
         ready_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         dac_reg <= dac_next;
         tgt_reg <= tgt_next;
         ov_latch_reg <= ov_latch_next;
         ov_pull_reg <= ov_pull_next;
         ov_sel_reg <= ov_sel_next;
         uv_ok_reg <= uv_ok_next;
         pwm_oe_reg <= oe_next;
         pwm_lvl_reg <= lvl_next;
         ready_reg <= ready_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, then a single answer cycle
   wire req = I_AVS_READ | I_AVS_WRITE;
   wire wr_ok = I_AVS_WRITE & ~wait_reg;
   wire lane0 = I_AVS_BYTEENABLE[0];
   wire [31:0] status_word = {7'h00, dac_reg, 9'h000, uv_ok_reg, ov_sel_reg, ov_latch_reg, ready_reg, state_reg};
   wire [31:0] rd_mux = (I_AVS_ADDRESS == REG_OFFSET) ? {24'h000000, offset_reg} :
      (I_AVS_ADDRESS == REG_STATUS) ? status_word :
      (I_AVS_ADDRESS == REG_IRQ_STATUS) ? {27'h0000000, irq_st_reg} :
      (I_AVS_ADDRESS == REG_IRQ_ENABLE) ? {27'h0000000, irq_en_reg} : 32'h00000000;
   wire [IRQ_W-1:0] irq_clr = (wr_ok && lane0 && I_AVS_ADDRESS == REG_IRQ_CLEAR) ? I_AVS_WRITEDATA[4:0] : 5'h00;
   wire [IRQ_W-1:0] irq_ev = {(state_next == ST_OFF) & (state_reg != ST_OFF),
      (state_next == ST_HICCUP) & (state_reg != ST_HICCUP), ov_now & ~ov_latch_reg,
      ~ready_next & ready_reg, ready_next & ~ready_reg};
   // Set wins over clear so an event in the clearing cycle survives
   wire [IRQ_W-1:0] irq_st_next = (irq_st_reg & ~irq_clr) | irq_ev;

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         offset_reg <= OFFSET_RST;
         irq_en_reg <= IRQ_EN_RST;
         irq_st_reg <= 5'h00;
         irq_reg <= 1'b0;
      end else begin
         wait_reg <= ~(req & wait_reg);
         if (req && wait_reg) begin
            rdata_reg <= rd_mux;
         end
         if (wr_ok && lane0 && I_AVS_ADDRESS == REG_OFFSET) begin
            offset_reg <= I_AVS_WRITEDATA[7:0];
         end
         if (wr_ok && lane0 && I_AVS_ADDRESS == REG_IRQ_ENABLE) begin
            irq_en_reg <= I_AVS_WRITEDATA[4:0];
         end
         irq_st_reg <= irq_st_next;
         irq_reg <= |(irq_st_next & irq_en_reg);
      end
   end

   // Output wiring, all from flops
   assign O_AVS_READDATA = rdata_reg;
   assign O_AVS_WAITREQUEST = wait_reg;
   assign O_PWM_LEVEL = pwm_lvl_reg;
   assign O_PWM_OE = pwm_oe_reg;
   assign O_REF_DAC = dac_reg;
   assign O_OV_SEL_CODED = ov_sel_reg;
   assign O_REGULATOR_READY = ready_reg;
   assign O_IRQ = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   localparam int HOLD_LAST = HOLD_CYC - 1;
   localparam int HIC_LAST = HICCUP_SW_CYC - 1;
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_B);

   sequence s_hold_done;
      state_reg == ST_HOLD && tmr_reg == 16'(HOLD_LAST) && vid_ok;
   endsequence
   sequence s_ov_ended;
      ov_pull_reg && !ov_now && !cmp_s2_reg.differential_sense_level;
   endsequence

   a_shut_hiz: assert property ((state_reg == ST_SHUT && !ov_pull_next) |=> O_PWM_OE == '0)
      else $error("PWM driven in shutdown");
   a_release_gate: assert property ((state_reg == ST_DELAY && $past(state_reg) == ST_SHUT) |-> $past(en_ok))
      else $error("Left shutdown without enables");
   a_boot_first: assert property (s_hold_done |-> dac_reg == BOOT_LEVEL)
      else $error("Code read before boot level");
   a_off_stays: assert property ((state_reg == ST_OFF && en_ok && !ov_latch_reg) |=> state_reg == ST_OFF)
      else $error("Off state left while enabled");
   a_init_delay: assert property ((state_reg == ST_RAMP_BOOT && $past(state_reg) == ST_DELAY) |->
      $past(tmr_reg) == 16'(P_INIT_DELAY_CYC - 1))
      else $error("Initial delay wrong");
   a_hold_qual: assert property ((state_reg == ST_RAMP_TGT && $past(state_reg) == ST_HOLD) |->
      $past(vstab_reg) == 4'(VID_QUAL_CYC) && $past(tmr_reg) == 16'(HOLD_LAST))
      else $error("Hold too short");
   a_dac_step: assert property ((active && $changed(dac_reg) && $past(active)) |-> $past(ss_tick) &&
      (dac_reg == $past(dac_reg) + 9'h001 || dac_reg == $past(dac_reg) - 9'h001))
      else $error("DAC step not one per tick");
   a_ramp_target: assert property ((state_reg == ST_RUN && $past(state_reg) == ST_RAMP_TGT) |-> dac_reg == tgt_reg)
      else $error("Second ramp ended off target");
   a_ready_delay: assert property ($rose(O_REGULATOR_READY) |-> $past(state_reg) == ST_RUN &&
      $past(tmr_reg) == 16'(READY_CYC))
      else $error("Ready without delay");
   a_ready_drop: assert property ((ov_now || !uv_ok_reg || !en_ok) |=> !O_REGULATOR_READY)
      else $error("Ready high during fault");
   a_uv_hyst: assert property ($rose(uv_ok_reg) |-> $past(cmp_s2_reg.sense_above_recover))
      else $error("Undervoltage recovered early");
   a_ov_always: assert property ((cmp_s2_reg.por_ok && cmp_s2_reg.ov_fixed_trip && !ov_sel_reg) |=>
      (O_PWM_OE == '1 && O_PWM_LEVEL == '0))
      else $error("Overvoltage ignored");
   a_ov_select: assert property ((state_reg == ST_SHUT || state_reg == ST_DELAY || state_reg == ST_RAMP_BOOT ||
      state_reg == ST_HOLD || state_reg == ST_HICCUP || state_reg == ST_OFF) |-> !O_OV_SEL_CODED)
      else $error("Overvoltage level select wrong");
   a_ov_release: assert property (s_ov_ended |=> !ov_pull_reg ##0 (O_PWM_LEVEL == '0))
      else $error("Overvoltage pull not released");
   a_ov_block: assert property (ov_latch_reg |=> state_reg == ST_SHUT)
      else $error("Run after overvoltage");
   a_avg_oc: assert property ((active && cmp_s2_reg.avg_overcurrent && en_ok && !ov_latch_reg) |=>
      state_reg == ST_HICCUP)
      else $error("Average overcurrent missed");
   // Phase 3 is the one the bench overloads; the count may only grow on a tick seen with the pin high
   a_chan_oc: assert property ((active && $past(active) && $past(sw_tick) && ccnt_reg[3] != 4'h0) |->
      $past(coc_s2_reg[3]))
      else $error("Channel count without overcurrent");
   a_hiccup_wait: assert property ((state_reg == ST_DELAY && $past(state_reg) == ST_HICCUP) |->
      $past(tmr_reg) == 16'(HIC_LAST) && $past(sw_tick))
      else $error("Hiccup wait wrong");
   a_sync_depth: assert property (##2 cmp_s2_reg == $past(I_CMP, 2))
      else $error("Comparator sync depth wrong");
endmodule : rsfs_sequencer
